//--- src/acs_pkg.sv
package acs_pkg;
    // Register word offsets on the Avalon bus (byte address = 4 * index).
    localparam logic [3:0] OFF_RESULT_HIGH   = 4'h0;
    localparam logic [3:0] OFF_RESULT_LOW    = 4'h1;
    localparam logic [3:0] OFF_CONV_CTRL_A   = 4'h2;
    localparam logic [3:0] OFF_CONV_CTRL_B   = 4'h3;
    localparam logic [3:0] OFF_BANDGAP_CTRL  = 4'h4;
    localparam logic [3:0] OFF_TEMP_CTRL     = 4'h5;
    localparam logic [3:0] OFF_REFT_HIGH     = 4'h6;
    localparam logic [3:0] OFF_REFT_LOW      = 4'h7;
    // Field positions in the first control register.
    localparam int BIT_START     = 7;
    localparam int BIT_BUSY      = 6;
    localparam int BIT_ENABLE    = 5;
    localparam int BIT_ALIGN     = 4;
    // Field positions in the second control register.
    localparam int POS_SOURCE    = 5;
    localparam int POS_REFSEL    = 3;
    localparam int POS_CLKDIV    = 0;
    // Field positions in the sensor and bandgap registers.
    localparam int BIT_BG_EN     = 0;
    localparam int BIT_TS_EN     = 0;
    localparam int BIT_FIXED_ONE = 1;
    // Reset values.
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic       RST_FIXED  = 1'b1;
    // Source codes.
    localparam logic [2:0] SRC_FORBIDDEN = 3'h7;
    localparam logic [2:0] SRC_TEMP      = 3'h2;
    // Timing in converter clocks.
    localparam logic [5:0] SAMPLE_CLKS      = 6'h04;
    localparam logic [5:0] SAMPLE_CLKS_TEMP = 6'h2E;
    localparam logic [5:0] CONVERT_CLKS     = 6'h0C;
    // Converter phase.
    typedef enum logic [1:0] {
        ACS_IDLE   = 2'b00,
        ACS_SAMPLE = 2'b01,
        ACS_CONV   = 2'b11
    } acs_phase_t;
endpackage : acs_pkg

//--- src/acs_clkdiv.sv
`timescale 1ns/1ps
// Produces a one-cycle tick every 2**div system clocks.
module acs_clkdiv
    import acs_pkg::*;
(
    // Clock and reset.
    input  wire logic       CLK,
    input  wire logic       RESET,
    // Control.
    input  wire logic       run,
    input  wire logic [2:0] div,
    // Tick output.
    output logic            tick
);
    typedef struct packed {
        logic [6:0] cnt;   // Prescaler count, zero while not running.
    } acs_div_state_t;

    acs_div_state_t state_reg;   // Registered state.
    acs_div_state_t state_next;  // Next state.
    logic [6:0]     limit;       // Terminal count for the ratio.

    // The terminal count is 2**div minus one, so code zero ticks every cycle.
    always_comb begin
        state_next = state_reg;
        limit      = 7'(({7'h00, 1'b1} << div) - 8'h01);
        tick       = run && (state_reg.cnt == limit);
        // Restart the count whenever a conversion is not running.
        if (!run || tick) begin
            state_next.cnt = 7'h00;
        end else begin
            state_next.cnt = state_reg.cnt + 7'h01;
        end
    end

    // State register.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // acs_clkdiv

//--- src/acs_top.sv
`timescale 1ns/1ps
module acs_top
    import acs_pkg::*;
#(
    parameter int RESULT_W = 12
)
(
    // Clock and reset.
    input  wire logic                CLK,
    input  wire logic                RESET,
    // Avalon-MM slave.
    input  wire logic [3:0]          AVS_ADDRESS,
    input  wire logic                AVS_READ,
    input  wire logic                AVS_WRITE,
    input  wire logic [31:0]         AVS_WRITEDATA,
    input  wire logic [3:0]          AVS_BYTEENABLE,
    output logic [31:0]              AVS_READDATA,
    output logic                     AVS_WAITREQUEST,
    // Analog core: sampled result and stored reference-temperature value.
    input  wire logic [RESULT_W-1:0] ANALOG_RESULT,
    input  wire logic [RESULT_W-1:0] REF_TEMP_VALUE,
    // Analog core control.
    output logic                     CONVERTER_POWER,
    output logic                     SAMPLE_HOLD,
    output logic                     CONV_CLOCK_TICK,
    output logic [8:0]               EXTERNAL_CHANNEL_ONEHOT,
    output logic [4:0]               INTERNAL_SOURCE_ONEHOT,
    output logic [1:0]               REFERENCE_SELECT,
    output logic                     BANDGAP_OUTPUT_ENABLE,
    output logic                     TEMP_SENSOR_ENABLE,
    output logic                     RESERVED_FIXED_ONE,
    // Request toward the interrupt controller.
    output logic                     CONV_DONE_IRQ
);
    typedef struct packed {
        logic [7:0]          ctrl_a;      // Start, busy, enable, align, channel.
        logic [7:0]          ctrl_b;      // Source, reference, divider.
        logic                bg_en;       // Bandgap enable.
        logic                ts_en;       // Sensor enable.
        logic                fixed_one;   // Reserved bit held at one.
        logic                armed;       // Start bit seen high.
        acs_phase_t          phase;       // Converter phase.
        logic [5:0]          clk_cnt;     // Converter clocks left in phase.
        logic [RESULT_W-1:0] result;      // Last conversion result.
        logic                irq;         // One-cycle completion pulse.
        logic                ack;         // Bus answer strobe.
        logic [31:0]         rdata;       // Registered read data.
    } acs_state_t;

    acs_state_t state_reg;    // Registered state.
    acs_state_t state_next;   // Next state.
    logic       tick;         // Converter clock tick.
    logic       req;          // Pending bus request.
    logic       wr_lane0;     // Write strobe with the data lane present.
    logic [7:0] wbyte;        // Written byte.
    logic [7:0] rbyte;        // Byte being read.
    logic [RESULT_W-1:0] r;   // Alias of the stored result.
    logic       run;          // Converter clock runs in a conversion.

    assign run = (state_reg.phase != ACS_IDLE);

    // Converter clock prescaler.
    acs_clkdiv u_clkdiv (
        .CLK   (CLK),
        .RESET (RESET),
        .run   (run),
        .div   (state_reg.ctrl_b[POS_CLKDIV +: 3]),
        .tick  (tick)
    );

    // Next-state logic: bus access, start detection and conversion timing.
    always_comb begin
        state_next     = state_reg;
        req            = (AVS_READ || AVS_WRITE) && !state_reg.ack;
        // Writes land in the accepting cycle, the one in which waitrequest is low.
        wr_lane0       = AVS_WRITE && state_reg.ack && AVS_BYTEENABLE[0];
        wbyte          = AVS_WRITEDATA[7:0];
        r              = state_reg.result;
        rbyte          = 8'h00;
        state_next.ack = req;
        state_next.irq = 1'b0;

        // Read multiplexer; unmapped words and unused bits read zero.
        unique case (AVS_ADDRESS)
            OFF_RESULT_HIGH: begin
                rbyte = state_reg.ctrl_a[BIT_ALIGN] ? {4'h0, r[11:8]} : r[11:4];
            end
            OFF_RESULT_LOW: begin
                rbyte = state_reg.ctrl_a[BIT_ALIGN] ? r[7:0] : {r[3:0], 4'h0};
            end
            OFF_CONV_CTRL_A:  rbyte = state_reg.ctrl_a;
            OFF_CONV_CTRL_B:  rbyte = state_reg.ctrl_b;
            OFF_BANDGAP_CTRL: rbyte = {7'h00, state_reg.bg_en};
            OFF_TEMP_CTRL:    rbyte = {6'h00, state_reg.fixed_one, state_reg.ts_en};
            OFF_REFT_HIGH:    rbyte = REF_TEMP_VALUE[11:4];
            OFF_REFT_LOW:     rbyte = {REF_TEMP_VALUE[3:0], 4'h0};
            default:          rbyte = 8'h00;
        endcase
        state_next.rdata = (AVS_READ && req) ? {24'h00_0000, rbyte} : state_reg.rdata;

        // Register writes; only the low byte lane carries data.
        if (wr_lane0) begin
            unique case (AVS_ADDRESS)
                OFF_CONV_CTRL_A: begin
                    state_next.ctrl_a = {wbyte[7], state_reg.ctrl_a[BIT_BUSY], wbyte[5:0]};
                end
                OFF_CONV_CTRL_B: begin
                    if (wbyte[POS_SOURCE +: 3] == SRC_FORBIDDEN) begin
                        state_next.ctrl_b = {state_reg.ctrl_b[7:5], wbyte[4:0]};
                    end else begin
                        state_next.ctrl_b = wbyte;
                    end
                end
                OFF_BANDGAP_CTRL: state_next.bg_en = wbyte[BIT_BG_EN];
                OFF_TEMP_CTRL: begin
                    state_next.ts_en = wbyte[BIT_TS_EN];
                    state_next.fixed_one = RST_FIXED;
                end
                default: begin
                    // Read-only and unmapped words ignore writes.
                end
            endcase
        end

        if (state_reg.ctrl_a[BIT_START]) begin
            state_next.armed = 1'b1;
        end
        if (state_reg.armed && !state_reg.ctrl_a[BIT_START]) begin
            state_next.armed = 1'b0;
            if (state_reg.phase == ACS_IDLE && state_reg.ctrl_a[BIT_ENABLE]) begin
                state_next.phase = ACS_SAMPLE;
                state_next.clk_cnt = (state_reg.ctrl_b[POS_SOURCE +: 3] == SRC_TEMP) ?
                                     SAMPLE_CLKS_TEMP : SAMPLE_CLKS;
                state_next.ctrl_a[BIT_BUSY] = 1'b1;
            end
        end

        // Conversion timing in converter clock ticks.
        if (tick) begin
            unique case (state_reg.phase)
                ACS_SAMPLE: begin
                    if (state_reg.clk_cnt == 6'h01) begin
                        state_next.phase   = ACS_CONV;
                        state_next.clk_cnt = CONVERT_CLKS;
                    end else begin
                        state_next.clk_cnt = state_reg.clk_cnt - 6'h01;
                    end
                end
                ACS_CONV: begin
                    if (state_reg.clk_cnt == 6'h01) begin
                        state_next.phase = ACS_IDLE;
                        state_next.ctrl_a[BIT_BUSY] = 1'b0;
                        state_next.result = ANALOG_RESULT;
                        state_next.irq = 1'b1;
                    end else begin
                        state_next.clk_cnt = state_reg.clk_cnt - 6'h01;
                    end
                end
                default: begin
                    // No ticks arrive while idle.
                end
            endcase
        end

        if (!state_next.ctrl_a[BIT_ENABLE]) begin
            state_next.phase = ACS_IDLE;
            state_next.ctrl_a[BIT_BUSY] = 1'b0;
            state_next.result = state_reg.result;
            state_next.irq = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg           <= '0;
            state_reg.ctrl_a    <= RST_CTRL_A;
            state_reg.ctrl_b    <= RST_CTRL_B;
            state_reg.fixed_one <= RST_FIXED;
            state_reg.phase     <= ACS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus answer: one wait cycle, then ready with registered data.
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !state_reg.ack;
    assign AVS_READDATA    = state_reg.rdata;

    // Analog control outputs.
    assign CONVERTER_POWER    = state_reg.ctrl_a[BIT_ENABLE];
    assign SAMPLE_HOLD        = (state_reg.phase == ACS_SAMPLE);
    assign CONV_CLOCK_TICK    = tick;
    assign REFERENCE_SELECT   = state_reg.ctrl_b[POS_REFSEL +: 2];
    assign BANDGAP_OUTPUT_ENABLE = state_reg.bg_en;
    assign TEMP_SENSOR_ENABLE = state_reg.ts_en;
    assign RESERVED_FIXED_ONE = state_reg.fixed_one;
    assign CONV_DONE_IRQ      = state_reg.irq;

    // Input routing decoded per channel and per internal source.
    for (genvar g = 0; g < 9; g++) begin : g_ext
        logic [2:0] s;
        assign s = state_reg.ctrl_b[POS_SOURCE +: 3];
        // external for codes 000 and 110
        assign EXTERNAL_CHANNEL_ONEHOT[g] = (g != 4) && (s == 3'h0 || s == 3'h6) &&
                                            (state_reg.ctrl_a[3:0] == 4'(g));
    end
    for (genvar g = 0; g < 5; g++) begin : g_int
        assign INTERNAL_SOURCE_ONEHOT[g] = (state_reg.ctrl_b[POS_SOURCE +: 3] == 3'(g + 1));
    end
endmodule // acs_top

//--- tb/acs_top_assertions.sv
`timescale 1ns/1ps
// Port-level checker for the converter control block.
module acs_top_assertions (
    // Clock, reset and bus handshake.
    input wire logic        CLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST,
    input wire logic [31:0] AVS_READDATA,
    // Converter side.
    input wire logic        CONVERTER_POWER, SAMPLE_HOLD, CONV_CLOCK_TICK, RESERVED_FIXED_ONE, CONV_DONE_IRQ,
    input wire logic [8:0]  EXTERNAL_CHANNEL_ONEHOT,
    input wire logic [4:0]  INTERNAL_SOURCE_ONEHOT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Ticks counted in sampling, and since sampling ended.
    logic [5:0] samp_reg, samp_next, conv_reg, conv_next;
    // Counts restart at each phase, so an aborted run cannot leak into the next one.
    always_comb begin
        samp_next = SAMPLE_HOLD ? samp_reg + {5'h00, CONV_CLOCK_TICK} : 6'h00;
        conv_next = SAMPLE_HOLD ? 6'h00 : conv_reg + {5'h00, CONV_CLOCK_TICK};
    end
    // Helper counters register here.
    always_ff @(posedge CLK) begin
        samp_reg <= RESET ? 6'h00 : samp_next;
        conv_reg <= RESET ? 6'h00 : conv_next;
    end
    AST_WAIT_FIRST: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
        else $error("First request cycle not stalled.");
    AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("Request stalled for more than one cycle.");
    AST_READ_UPPER: assert property (AVS_READDATA[31:8] == 24'h00_0000)
        else $error("Upper read data not zero.");
    AST_SAMPLE_LEN: assert property ($fell(SAMPLE_HOLD) && CONVERTER_POWER |-> samp_reg == 6'h04 || samp_reg == 6'h2E)
        else $error("Sampling phase length wrong.");
    AST_CONV_LEN: assert property ($rose(CONV_DONE_IRQ) |-> conv_reg == 6'h0C)
        else $error("Conversion phase length wrong.");
    AST_IRQ_PULSE: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
        else $error("Completion request longer than one cycle.");
    AST_IRQ_IDLE: assert property (CONV_DONE_IRQ |-> !SAMPLE_HOLD && !CONV_CLOCK_TICK)
        else $error("Converter still active at completion.");
    AST_TICK_POWER: assert property (CONV_CLOCK_TICK |-> CONVERTER_POWER)
        else $error("Converter clock while switched off.");
    AST_FIXED_ONE: assert property (RESERVED_FIXED_ONE)
        else $error("Reserved bit not one.");
    AST_CH_ONEHOT: assert property (!EXTERNAL_CHANNEL_ONEHOT[4] && $onehot0(EXTERNAL_CHANNEL_ONEHOT))
        else $error("Bad external channel selection.");
    AST_SRC_EXCLUSIVE: assert property ($onehot0(INTERNAL_SOURCE_ONEHOT) &&
        !(|INTERNAL_SOURCE_ONEHOT && |EXTERNAL_CHANNEL_ONEHOT))
        else $error("Internal and external inputs selected together.");
endmodule // acs_top_assertions

//--- tb/acs_top_tb.sv
`timescale 1ns/1ps
// Register-level bench for the converter control block.
module acs_top_tb;
    import acs_pkg::*;
    // Bus and analog side.
    logic        CLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CONVERTER_POWER, SAMPLE_HOLD, CONV_CLOCK_TICK;
    logic        BANDGAP_OUTPUT_ENABLE, TEMP_SENSOR_ENABLE, RESERVED_FIXED_ONE, CONV_DONE_IRQ;
    logic [3:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [11:0] ANALOG_RESULT, REF_TEMP_VALUE;
    logic [8:0]  EXTERNAL_CHANNEL_ONEHOT;
    logic [4:0]  INTERNAL_SOURCE_ONEHOT;
    logic [1:0]  REFERENCE_SELECT;
    // Bookkeeping.
    int          n_mismatch, checks_done, irq_seen, samp_cycles;
    logic [7:0]  q;
    acs_top dut (
        .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .ANALOG_RESULT(ANALOG_RESULT), .REF_TEMP_VALUE(REF_TEMP_VALUE),
        .CONVERTER_POWER(CONVERTER_POWER), .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_CLOCK_TICK(CONV_CLOCK_TICK),
        .EXTERNAL_CHANNEL_ONEHOT(EXTERNAL_CHANNEL_ONEHOT), .INTERNAL_SOURCE_ONEHOT(INTERNAL_SOURCE_ONEHOT),
        .REFERENCE_SELECT(REFERENCE_SELECT), .BANDGAP_OUTPUT_ENABLE(BANDGAP_OUTPUT_ENABLE),
        .TEMP_SENSOR_ENABLE(TEMP_SENSOR_ENABLE), .RESERVED_FIXED_ONE(RESERVED_FIXED_ONE), .CONV_DONE_IRQ(CONV_DONE_IRQ)
    );
    // Free-running system clock.
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // Completion requests are counted as they pass.
    always @(posedge CLK) begin
        if (CONV_DONE_IRQ === 1'b1) irq_seen++;
        // Sampling cycles are summed to check the converter clock ratio.
        if (SAMPLE_HOLD === 1'b1) samp_cycles++;
    end
    // Compares one value with its expectation.
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One bus transfer; the request holds until waitrequest is sampled low.
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h00_0000, d};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 64);
        if (n >= 64) n_mismatch++;
        q = AVS_READDATA[7:0];
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        // Let register outputs settle before anyone looks at them.
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk({4'h0, q}, {4'h0, exp});
    endtask
    // Polls the busy flag, the way software without interrupts would.
    // poll busy flag
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            xfer(1'b0, OFF_CONV_CTRL_A, 8'h00);
            n++;
        end while (q[BIT_BUSY] !== 1'b0 && n < 300);
        if (n >= 300) n_mismatch++;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("Checks made: %0d, mismatches: %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under this many cycles.
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        {RESET, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {3'b100, 4'h0, 32'h0000_0000};
        {ANALOG_RESULT, REF_TEMP_VALUE} = {12'hABC, 12'h9D7};
        {n_mismatch, checks_done, irq_seen, samp_cycles} = {32'd0, 32'd0, 32'd0, 32'd0};
        repeat (8) @(posedge CLK);
        RESET <= 1'b0;
        rdc(OFF_CONV_CTRL_A, 8'h00);
        rdc(OFF_CONV_CTRL_B, 8'h00);
        rdc(OFF_TEMP_CTRL, 8'h02);
        rdc(4'hC, 8'h00);
        wr(OFF_BANDGAP_CTRL, 8'hFF);
        rdc(OFF_BANDGAP_CTRL, 8'h01);
        chk(BANDGAP_OUTPUT_ENABLE, 12'h001);
        wr(OFF_TEMP_CTRL, 8'hFD);
        rdc(OFF_TEMP_CTRL, 8'h03);
        chk(TEMP_SENSOR_ENABLE, 12'h001);
        wr(OFF_BANDGAP_CTRL, 8'h00);
        chk(BANDGAP_OUTPUT_ENABLE, 12'h000);
        $display("test register defaults done");
        // bandgap on before its source is chosen.
        wr(OFF_BANDGAP_CTRL, 8'h01);
        // no-channel code while internal sources are walked.
        wr(OFF_CONV_CTRL_A, 8'h0C);
        // pin functions live outside this block, so any reference code is harmless here.
        // Source codes 0 to 6, with the reference code walked alongside.
        for (int s = 0; s < 7; s++) begin
            wr(OFF_CONV_CTRL_B, {s[2:0], s[1:0], 3'h0});
            chk(INTERNAL_SOURCE_ONEHOT, (s inside {[1:5]}) ? 12'(1 << (s - 1)) : 12'h000);
            chk(REFERENCE_SELECT, {10'h000, s[1:0]});
        end
        wr(OFF_CONV_CTRL_B, 8'hE5);
        rdc(OFF_CONV_CTRL_B, 8'hC5);
        // Every channel code, each write also trying to set the busy flag.
        for (int c = 0; c < 16; c++) begin
            wr(OFF_CONV_CTRL_A, 8'h40 | c[7:0]);
            rdc(OFF_CONV_CTRL_A, {4'h0, c[3:0]});
            chk(EXTERNAL_CHANNEL_ONEHOT, (c < 9 && c != 4) ? 12'(1 << c) : 12'h000);
        end
        $display("test field tables done");
        wr(OFF_CONV_CTRL_B, 8'h00);
        wr(OFF_CONV_CTRL_A, 8'hA0);
        rdc(OFF_CONV_CTRL_A, 8'hA0);
        wr(OFF_CONV_CTRL_A, 8'h20);
        rdc(OFF_CONV_CTRL_A, 8'h60);
        wait_idle();
        rdc(OFF_RESULT_HIGH, 8'hAB);
        rdc(OFF_RESULT_LOW, 8'hC0);
        chk(irq_seen[11:0], 12'h001);
        // Sensor source at a divided clock, with a second start pulse mid-run.
        wr(OFF_CONV_CTRL_B, 8'h42);
        ANALOG_RESULT <= 12'h5A3;
        for (int p = 0; p < 2; p++) begin
            // no-channel code with the sensor source.
            wr(OFF_CONV_CTRL_A, 8'hBC);
            wr(OFF_CONV_CTRL_A, 8'h3C);
        end
        wait_idle();
        rdc(OFF_CONV_CTRL_A, 8'h3C);
        rdc(OFF_RESULT_HIGH, 8'h05);
        rdc(OFF_RESULT_LOW, 8'hA3);
        chk(irq_seen[11:0], 12'h002);
        // Sampling ran 4 ticks at full rate, then 46 ticks at a quarter of it.
        chk(samp_cycles[11:0], 12'h0BC);
        $display("test conversions done");
        // Switched off: no start, results held; then an aborted run.
        ANALOG_RESULT <= 12'h777;
        wr(OFF_CONV_CTRL_A, 8'h9C);
        wr(OFF_CONV_CTRL_A, 8'h1C);
        wr(OFF_RESULT_HIGH, 8'hFF);
        rdc(OFF_CONV_CTRL_A, 8'h1C);
        wr(OFF_CONV_CTRL_B, 8'h07);
        wr(OFF_CONV_CTRL_A, 8'hB0);
        wr(OFF_CONV_CTRL_A, 8'h30);
        wr(OFF_CONV_CTRL_A, 8'h10);
        rdc(OFF_RESULT_HIGH, 8'h05);
        rdc(OFF_RESULT_LOW, 8'hA3);
        chk(irq_seen[11:0], 12'h002);
        wr(OFF_REFT_LOW, 8'hFF);
        rdc(OFF_REFT_HIGH, 8'h9D);
        rdc(OFF_REFT_LOW, 8'h70);
        $display("test disable and reference pair done");
        wrap_up();
    end
endmodule // acs_top_tb
bind acs_top acs_top_assertions u_chk (
    .CLK(CLK), .RESET(RESET), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_READDATA(AVS_READDATA), .CONVERTER_POWER(CONVERTER_POWER), .SAMPLE_HOLD(SAMPLE_HOLD),
    .CONV_CLOCK_TICK(CONV_CLOCK_TICK), .RESERVED_FIXED_ONE(RESERVED_FIXED_ONE), .CONV_DONE_IRQ(CONV_DONE_IRQ),
    .EXTERNAL_CHANNEL_ONEHOT(EXTERNAL_CHANNEL_ONEHOT), .INTERNAL_SOURCE_ONEHOT(INTERNAL_SOURCE_ONEHOT)
);
